// ==== dcsp_top.v ====
// Summary of operation
// - Select pin high enables serial registers; low runs from control pins.
// - Eight eight-bit registers sit behind the serial port.
// - Frame is read/write bit, four unused bits, three address bits, eight data bits, MSB first.
// - MOSI sampled on SCK rise; MISO changes on SCK fall.
// - Previous frame shifts out on MISO while the new one shifts in.
// - MISO is driven only while select is low.
// - Dummy frame carries addressed register data in its last eight bits.
// - Read data bits and dummy frames only pass along the shift path.
// - Auto sleep pin high and no signal enters power-save; signal wakes.
// - Auto sleep pin low never sleeps for lack of signal.
// - A serial register bit forces power-down regardless of signal.
// - Sleep overrides mute and bypass.
// - Auto power-down completes within 200 us of signal loss.
// - Ready asserts about 5 ms after signal returns.
// - Swing selects 400, 600, 700 or 800 mV; 700 after reset.
// - Common level programmable 0.8 V to 1.2 V, default 1.2 V, plus supply.
// - De-emphasis setting is independent of swing and common level.
// - Writes commit only when select rises.
// - Read command captures addressed register into shifter at select rise.
// - Signal-present output low while a valid input is detected.
// - Mute high holds video output at 1; low passes equalized data.
`default_nettype none
`include "dcsp_regs.vh"
module dcsp_top #(
	parameter SLEEP_CYC = `DCSP_SLEEP_CYC,
	parameter WAKE_CYC  = `DCSP_WAKE_CYC
) (
	input  wire       CLK,
	input  wire       RESET,
	input  wire       SPI_EN,
	input  wire       SCK,
	input  wire       SS_N,
	input  wire       MOSI,
	output reg        MISO_O,
	output reg        MISO_OE,
	input  wire       AUTO_SLEEP,
	input  wire       SIGNAL_DETECT,
	input  wire       MUTE,
	input  wire       BYPASS,
	input  wire       EQ_DATA,
	output reg        SIGNAL_PRESENT_N,
	output reg        SERIAL_VIDEO_OUT,
	output reg        POWER_DOWN,
	output reg        READY,
	output reg        BYPASS_ACTIVE,
	output reg  [1:0] OUTPUT_SWING_LEVEL,
	output reg  [1:0] OUTPUT_COMMON_LEVEL,
	output reg  [2:0] DEEMPHASIS
);
	////////////////////////////////////////////////////////////////////////
	// Input synchronisers.
	wire spi_en_s;
	wire sck_s;
	wire ss_n_s;
	wire mosi_s;
	wire auto_s;
	wire det_s;
	wire mute_s;
	wire byp_s;
	wire [7:0] async_in;
	wire [7:0] sync_out;
	assign async_in = {BYPASS, MUTE, SIGNAL_DETECT, AUTO_SLEEP,
		MOSI, SS_N, SCK, SPI_EN};
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
			dcsp_sync u_sync (
				.CLK   (CLK),
				.RESET (RESET),
				.d     (async_in[gi]),
				.q     (sync_out[gi])
			);
		end
	endgenerate
	assign {byp_s, mute_s, det_s, auto_s, mosi_s, ss_n_s, sck_s, spi_en_s} =
		sync_out;

	////////////////////////////////////////////////////////////////////////
	// Edge detection.
	reg sck_d_reg;
	reg ss_d_reg;
	reg [7:0] regs [0:`DCSP_REG_COUNT-1];
	reg [15:0] shift_reg;
	wire sck_rise;
	wire sck_fall;
	wire ss_rise;
	wire spi_act;
	assign spi_act  = spi_en_s;
	assign sck_rise = sck_s & ~sck_d_reg & ~ss_n_s & spi_act;
	assign sck_fall = ~sck_s & sck_d_reg & ~ss_n_s & spi_act;
	assign ss_rise  = ss_n_s & ~ss_d_reg & spi_act;
	always @(posedge CLK) begin
		if (RESET) begin
			sck_d_reg <= 1'b0;
			ss_d_reg  <= 1'b1;
		end else begin
			sck_d_reg <= sck_s;
			ss_d_reg  <= ss_n_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shift path and register file.
	function [2:0] frame_addr;
		input [15:0] f;
		frame_addr = f[8 +: `DCSP_ADDR_W];
	endfunction
	wire [15:0] shift_next;
	assign shift_next = {shift_reg[14:0], mosi_s};
	integer i;
	always @(posedge CLK) begin
		if (RESET) begin
			shift_reg <= 16'h0000;
			for (i = 0; i < `DCSP_REG_COUNT; i = i + 1) begin
				regs[i] <= `DCSP_RST_OTHER;
			end
			regs[`DCSP_ADDR_SLEEP]  <= `DCSP_RST_SLEEP;
			regs[`DCSP_ADDR_DRIVER] <= `DCSP_RST_DRIVER;
		end else if (sck_rise) begin
			shift_reg <= shift_next;
		end else if (ss_rise) begin
			if (shift_reg[15]) begin
				// An all-ones dummy frame is not a read command.
				if (~&shift_reg) begin
					shift_reg[7:0] <= regs[frame_addr(shift_reg)];
				end
			end else begin
				regs[frame_addr(shift_reg)] <= shift_reg[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// MISO drive.
	always @(posedge CLK) begin
		if (RESET) begin
			MISO_O  <= 1'b0;
			MISO_OE <= 1'b0;
		end else begin
			MISO_OE <= spi_act & ~ss_n_s;
			if (~ss_n_s & ss_d_reg) begin
				MISO_O <= shift_reg[15];
			end else if (sck_fall) begin
				MISO_O <= shift_reg[15];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sleep control.
	reg [17:0] loss_cnt_reg;
	reg [17:0] wake_cnt_reg;
	reg asleep_reg;
	wire force_sleep;
	wire sleep_now;
	assign force_sleep = spi_act &
		regs[`DCSP_ADDR_SLEEP][`DCSP_SLEEP_FORCE_BIT];
	assign sleep_now = asleep_reg | force_sleep;
	always @(posedge CLK) begin
		if (RESET) begin
			loss_cnt_reg <= 18'h0_0000;
			wake_cnt_reg <= 18'h0_0000;
			asleep_reg   <= 1'b0;
			READY        <= 1'b0;
		end else begin
			if (!auto_s || det_s) begin
				loss_cnt_reg <= 18'h0_0000;
				asleep_reg   <= 1'b0;
			end else if ({14'h0000, loss_cnt_reg} >= SLEEP_CYC) begin
				asleep_reg <= 1'b1;
			end else begin
				loss_cnt_reg <= loss_cnt_reg + 18'h0_0001;
			end
			if (sleep_now || !det_s) begin
				wake_cnt_reg <= 18'h0_0000;
				READY        <= 1'b0;
			end else if ({14'h0000, wake_cnt_reg} >= WAKE_CYC - 1) begin
				READY <= 1'b1;
			end else begin
				wake_cnt_reg <= wake_cnt_reg + 18'h0_0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.
	always @(posedge CLK) begin
		if (RESET) begin
			SIGNAL_PRESENT_N    <= 1'b1;
			SERIAL_VIDEO_OUT    <= 1'b1;
			POWER_DOWN          <= 1'b0;
			BYPASS_ACTIVE       <= 1'b0;
			OUTPUT_SWING_LEVEL  <= 2'h2;
			OUTPUT_COMMON_LEVEL <= 2'h2;
			DEEMPHASIS          <= 3'h0;
		end else begin
			SIGNAL_PRESENT_N <= ~det_s;
			POWER_DOWN       <= sleep_now;
			BYPASS_ACTIVE    <= byp_s & ~sleep_now;
			if (sleep_now || mute_s) begin
				SERIAL_VIDEO_OUT <= 1'b1;
			end else begin
				SERIAL_VIDEO_OUT <= EQ_DATA;
			end
			if (spi_act) begin
				OUTPUT_SWING_LEVEL <= regs[`DCSP_ADDR_DRIVER]
					[`DCSP_SWING_HI:`DCSP_SWING_LO];
				OUTPUT_COMMON_LEVEL <= regs[`DCSP_ADDR_DRIVER]
					[`DCSP_COMMON_HI:`DCSP_COMMON_LO];
				DEEMPHASIS <= regs[`DCSP_ADDR_DRIVER]
					[`DCSP_DEEMPH_HI:`DCSP_DEEMPH_LO];
			end else begin
				OUTPUT_SWING_LEVEL  <= 2'h2;
				OUTPUT_COMMON_LEVEL <= 2'h2;
				DEEMPHASIS          <= 3'h0;
			end
		end
	end
endmodule // dcsp_top
`default_nettype wire

// ==== dcsp_regs.vh ====
`ifndef DCSP_REGS_VH
`define DCSP_REGS_VH
`define DCSP_FRAME_BITS      5'h10
`define DCSP_ADDR_W          3
`define DCSP_REG_COUNT       8
`define DCSP_ADDR_SLEEP      3'h0
`define DCSP_ADDR_DRIVER     3'h1
`define DCSP_SLEEP_FORCE_BIT 4
`define DCSP_SWING_HI        7
`define DCSP_SWING_LO        6
`define DCSP_COMMON_HI       5
`define DCSP_COMMON_LO       4
`define DCSP_DEEMPH_HI       3
`define DCSP_DEEMPH_LO       1
`define DCSP_RST_SLEEP       8'h00
`define DCSP_RST_DRIVER      8'hA0
`define DCSP_RST_OTHER       8'h00
`define DCSP_CLK_MHZ         40
`define DCSP_SLEEP_US        200
`define DCSP_WAKE_US         5000
`define DCSP_SLEEP_CYC       ((`DCSP_SLEEP_US * `DCSP_CLK_MHZ) - 1)
`define DCSP_WAKE_CYC        (`DCSP_WAKE_US * `DCSP_CLK_MHZ)
`endif

// ==== dcsp_sync.v ====
`default_nettype none
module dcsp_sync (
	input  wire CLK,
	input  wire RESET,
	input  wire d,
	output reg  q
);
	reg meta_reg;
	always @(posedge CLK) begin
		if (RESET) begin
			meta_reg <= 1'b0;
			q        <= 1'b0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule // dcsp_sync
`default_nettype wire

// ==== dcsp_top_properties.sv ====
`default_nettype none
module dcsp_chk #(
	parameter SLEEP_CYC = 20
) (
	input wire logic       CLK,
	input wire logic       RESET,
	input wire logic       SPI_EN,
	input wire logic       SS_N,
	input wire logic       MISO_OE,
	input wire logic       AUTO_SLEEP,
	input wire logic       SIGNAL_DETECT,
	input wire logic       MUTE,
	input wire logic       EQ_DATA,
	input wire logic       SIGNAL_PRESENT_N,
	input wire logic       SERIAL_VIDEO_OUT,
	input wire logic       POWER_DOWN,
	input wire logic       BYPASS_ACTIVE,
	input wire logic [1:0] OUTPUT_SWING_LEVEL
);
	timeunit 1ns;
	timeprecision 1ps;
	int quiet_reg;
	always_ff @(posedge CLK) begin
		if (RESET || !AUTO_SLEEP || SIGNAL_DETECT) quiet_reg <= 0;
		else if (quiet_reg < 9999) quiet_reg <= quiet_reg + 1;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	a_oe_idle: assert property (SS_N [*6] |-> !MISO_OE)
		else $error("miso driven while idle");
	a_oe_pin: assert property (!SPI_EN [*6] |-> !MISO_OE)
		else $error("miso driven in pin mode");
	a_oe_drive: assert property (
		(SPI_EN && !SS_N) [*6] |-> MISO_OE)
		else $error("miso not driven");
	a_present_low: assert property (
		SIGNAL_DETECT [*6] |-> !SIGNAL_PRESENT_N)
		else $error("present flag wrong");
	a_mute_high: assert property (MUTE [*6] |-> SERIAL_VIDEO_OUT)
		else $error("mute not high");
	a_video_pass: assert property (
		!MUTE [*4] ##0 !POWER_DOWN |-> SERIAL_VIDEO_OUT == $past(EQ_DATA))
		else $error("video not passed");
	a_sleep_wins: assert property (POWER_DOWN [*3] |->
		SERIAL_VIDEO_OUT && !BYPASS_ACTIVE)
		else $error("sleep lost priority");
	a_sleep_time: assert property (
		quiet_reg > SLEEP_CYC + 8 |-> POWER_DOWN)
		else $error("sleep too late");
	a_pin_swing: assert property (
		!SPI_EN [*6] |-> OUTPUT_SWING_LEVEL == 2'h2)
		else $error("pin mode swing wrong");
	cover property (POWER_DOWN);
	cover property (MISO_OE);
	cover property (MUTE && SERIAL_VIDEO_OUT);
endmodule // dcsp_chk
bind dcsp_top dcsp_chk #(.SLEEP_CYC(SLEEP_CYC)) u_chk (
	.CLK(CLK), .RESET(RESET), .SPI_EN(SPI_EN), .SS_N(SS_N),
	.MISO_OE(MISO_OE), .AUTO_SLEEP(AUTO_SLEEP), .MUTE(MUTE),
	.EQ_DATA(EQ_DATA),
	.SIGNAL_DETECT(SIGNAL_DETECT), .SIGNAL_PRESENT_N(SIGNAL_PRESENT_N),
	.SERIAL_VIDEO_OUT(SERIAL_VIDEO_OUT), .POWER_DOWN(POWER_DOWN),
	.BYPASS_ACTIVE(BYPASS_ACTIVE), .OUTPUT_SWING_LEVEL(OUTPUT_SWING_LEVEL)
);
`default_nettype wire

// ==== dcsp_host.sv ====
`default_nettype none
module dcsp_host (
	input  wire logic CLK,
	output var  logic SCK,
	output var  logic SS_N,
	output var  logic MOSI,
	input  wire logic MISO_O,
	input  wire logic MISO_OE
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		SCK = 1'b0;
		SS_N = 1'b1;
		MOSI = 1'b0;
	end
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		SS_N = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			MOSI = tx[i];
			repeat (4) @(negedge CLK);
			SCK = 1'b1;
			repeat (4) @(negedge CLK);
			rx[i] = MISO_OE ? MISO_O : 1'bx;
			SCK = 1'b0;
		end
		repeat (4) @(negedge CLK);
		SS_N = 1'b1;
		MOSI = ~MOSI;
		repeat (12) @(negedge CLK);
	endtask
endmodule // dcsp_host
`default_nettype wire

// ==== dcsp_top_tb_top.sv ====
`default_nettype none
module dcsp_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 1'b0;
	logic RESET = 1'b1;
	logic SPI_EN = 1'b1;
	logic AUTO_SLEEP = 1'b0;
	logic SIGNAL_DETECT = 1'b1;
	logic MUTE = 1'b0;
	logic BYPASS = 1'b0;
	logic EQ_DATA = 1'b0;
	logic SCK, SS_N, MOSI, MISO_O, MISO_OE, SP_N, SVO, PD, RDY, BA;
	logic [1:0] SWG, CMN;
	logic [2:0] DEM;
	logic [15:0] exp_f, junk;
	int mem[8] = '{0, 8'hA0, 0, 0, 0, 0, 0, 0};
	int seed = 55638;
	int error_cnt = 0;
	int checked = 0;
	bit have = 0;
	initial forever #12.5 CLK = ~CLK;
	always @(negedge CLK) EQ_DATA <= 1'($random(seed));
	dcsp_top #(.SLEEP_CYC(20), .WAKE_CYC(50)) u_dcsp_top (
		.CLK(CLK), .RESET(RESET), .SPI_EN(SPI_EN), .SCK(SCK), .SS_N(SS_N),
		.MOSI(MOSI), .MISO_O(MISO_O), .MISO_OE(MISO_OE), .MUTE(MUTE),
		.AUTO_SLEEP(AUTO_SLEEP), .SIGNAL_DETECT(SIGNAL_DETECT),
		.BYPASS(BYPASS), .EQ_DATA(EQ_DATA), .SIGNAL_PRESENT_N(SP_N),
		.SERIAL_VIDEO_OUT(SVO), .POWER_DOWN(PD), .READY(RDY),
		.BYPASS_ACTIVE(BA), .OUTPUT_SWING_LEVEL(SWG),
		.OUTPUT_COMMON_LEVEL(CMN), .DEEMPHASIS(DEM));
	dcsp_host u_dcsp_host (.CLK(CLK), .SCK(SCK), .SS_N(SS_N),
		.MOSI(MOSI), .MISO_O(MISO_O), .MISO_OE(MISO_OE));
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up;
		if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic op(input logic [15:0] tx);
		logic [15:0] rx;
		u_dcsp_host.xfer(tx, rx);
		if (have) chk("miso", rx, exp_f);
		have = 1;
		exp_f = tx;
		if (!tx[15]) mem[tx[10:8]] = tx[7:0];
		else if (tx != 16'hFFFF) exp_f[7:0] = 8'(mem[tx[10:8]]);
	endtask
	task automatic lv;
		chk("levels", {9'h000, SWG, CMN, DEM}, 16'(mem[1][7:1]));
	endtask
	task automatic wait_on(input bit rdy, input logic lvl, input int lim);
		int n;
		for (n = 0; n < lim && (rdy ? RDY : PD) !== lvl; n++)
			@(negedge CLK);
		chk("power", 16'(rdy ? RDY : PD), 16'(lvl));
		if (n == lim) wrap_up();
	endtask
	initial begin
		repeat (10) @(negedge CLK);
		RESET = 1'b0;
		repeat (4) @(negedge CLK);
		for (int p = 0; p < 2; p++) begin
			for (int a = 0; a < 8; a++) begin
				op({1'b1, 4'($random(seed)), 3'(a), 8'hFF});
				op(16'hFFFF);
			end
			for (int a = 2; a < 8; a++)
				op({1'b0, 4'($random(seed)), 3'(a),
					8'($random(seed))});
		end
		for (int s = 0; s < 4; s++) begin
			op({8'h01, 2'(s), 6'($random(seed))});
			lv();
		end
		SPI_EN = 1'b0;
		repeat (8) @(negedge CLK);
		u_dcsp_host.xfer(16'h0100, junk);
		SPI_EN = 1'b1;
		repeat (8) @(negedge CLK);
		lv();
		BYPASS = 1'b1;
		op(16'h0010);
		wait_on(0, 1, 40);
		op(16'h0000);
		wait_on(0, 0, 40);
		wait_on(1, 1, 90);
		AUTO_SLEEP = 1'b1;
		SIGNAL_DETECT = 1'b0;
		wait_on(0, 1, 40);
		SIGNAL_DETECT = 1'b1;
		wait_on(0, 0, 20);
		wait_on(1, 1, 90);
		AUTO_SLEEP = 1'b0;
		SIGNAL_DETECT = 1'b0;
		MUTE = 1'b1;
		repeat (60) @(negedge CLK);
		chk("sleep", 16'(PD), 16'h0000);
		wrap_up();
	end
endmodule // dcsp_top_tb_top
`default_nettype wire
